// *** hdl/ext_pin_irq_ctrl.sv ***
/*
 * External pin interrupt control: pin input gating, active waveform select,
 * request flag with test-and-skip clear, per-source and global enables,
 * single-level service tracking and key-on wakeup from RAM back-up.
 * Assumes the instruction sequencer gives one-cycle op strobes on the system
 * clock and that the pin level is already synchronous to that clock.
 */
// Overview of operation
// - Pin input path is blocked while control bit 3 is 0; resets to 0.
// - Changing waveform select bit 2 may set the request flag per pin level.
// - Changing input enable bit 3 may set the request flag per pin level.
// - Test-skip op may skip the next instruction; software follows it with a no-op.
// - No nesting: no interrupt is accepted while a service routine runs.
// - Accepting an interrupt clears the global enable flag in that cycle.
// - Enable op then return op leaves interrupts enabled as control returns.
// - Wakeup left enabled on an undriven pin returns from back-up at once.
// - Test-skip op acts only while source enable bit 0 is 0.
`timescale 1ns/1ps
module ext_pin_irq_ctrl (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst,
    // AXI4-Lite register bus
    input wire logic [ext_pin_irq_pkg::ADDR_W-1:0] i_awaddr,
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    input wire logic i_wvalid,
    output logic o_wready,
    output logic [1:0] o_bresp,
    output logic o_bvalid,
    input wire logic i_bready,
    input wire logic [ext_pin_irq_pkg::ADDR_W-1:0] i_araddr,
    input wire logic i_arvalid,
    output logic o_arready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    output logic o_rvalid,
    input wire logic i_rready,
    // Pin and power state
    input wire logic i_shared_port_pin,
    input wire logic i_ram_backup,
    // Instruction sequencer strobes
    input wire logic i_instr_boundary,
    input wire logic i_test_skip_clear_request_op,
    input wire logic i_enable_irq_op,
    input wire logic i_disable_irq_op,
    input wire logic i_return_from_service_op,
    // Sequencer answers
    output logic o_vector_take,
    output logic o_skip_next,
    output logic o_wakeup,
    output logic o_irq
);
    import ext_pin_irq_pkg::*;

    logic [REG_W-1:0] pin_interrupt_control_reg_r;
    logic [REG_W-1:0] ext_irq_enable_reg_r;
    logic [REG_W-1:0] wakeup_select_reg_r;
    logic [EVT_W-1:0] irq_sts_r;
    logic [EVT_W-1:0] irq_mask_r;
    logic external_request_flag_r;
    logic global_irq_enable_flag_r;
    logic in_service_r;
    logic active_q_r;
    logic active;
    logic req_set;
    logic skip_clr;
    logic vector_now;
    logic wake_cond;
    logic [EVT_W-1:0] evt;
    logic wr_en;
    logic [ADDR_W-1:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic [ADDR_W-1:0] rd_addr;
    logic [31:0] rd_data;
    logic wr_low;

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    function automatic logic reg_hit(input logic [ADDR_W-1:0] a);
        reg_hit = (a == PIN_CTRL_OFS) || (a == EXT_EN_OFS) || (a == WAKE_SEL_OFS)
            || (a == CORE_STS_OFS) || (a == IRQ_STS_OFS) || (a == IRQ_MASK_OFS);
    endfunction : reg_hit

    axil_reg_slave #(
        .AW(ADDR_W)
    ) u_slave (
        .i_ref_clk(i_ref_clk),
        .i_rst(i_rst),
        .i_awaddr(i_awaddr),
        .i_awvalid(i_awvalid),
        .o_awready(o_awready),
        .i_wdata(i_wdata),
        .i_wstrb(i_wstrb),
        .i_wvalid(i_wvalid),
        .o_wready(o_wready),
        .o_bresp(o_bresp),
        .o_bvalid(o_bvalid),
        .i_bready(i_bready),
        .i_araddr(i_araddr),
        .i_arvalid(i_arvalid),
        .o_arready(o_arready),
        .o_rdata(o_rdata),
        .o_rresp(o_rresp),
        .o_rvalid(o_rvalid),
        .i_rready(i_rready),
        .o_wr_en(wr_en),
        .o_wr_addr(wr_addr),
        .o_wr_data(wr_data),
        .o_wr_strb(wr_strb),
        .i_wr_ok(reg_hit(wr_addr)),
        .o_rd_addr(rd_addr),
        .i_rd_data(rd_data),
        .i_rd_ok(reg_hit(rd_addr))
    );

    // All fields live in byte lane 0
    assign wr_low = wr_en && wr_strb[0];

    always_comb begin
        rd_data = 32'h0000_0000;
        unique case (rd_addr)
            PIN_CTRL_OFS: rd_data[REG_W-1:0] = pin_interrupt_control_reg_r;
            EXT_EN_OFS: rd_data[REG_W-1:0] = ext_irq_enable_reg_r;
            WAKE_SEL_OFS: rd_data[REG_W-1:0] = wakeup_select_reg_r;
            CORE_STS_OFS: begin
                rd_data[STS_FLAG_BIT] = external_request_flag_r;
                rd_data[STS_GIE_BIT] = global_irq_enable_flag_r;
                rd_data[STS_SERV_BIT] = in_service_r;
                rd_data[STS_WAKE_BIT] = o_wakeup;
                rd_data[STS_PIN_BIT] = i_shared_port_pin;
            end
            IRQ_STS_OFS: rd_data[EVT_W-1:0] = irq_sts_r;
            IRQ_MASK_OFS: rd_data[EVT_W-1:0] = irq_mask_r;
            default: rd_data = 32'h0000_0000;
        endcase
    end

    // ------------------------------------------------------------------
    // Software registers
    // ------------------------------------------------------------------
    // enable resets low
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            pin_interrupt_control_reg_r <= PIN_CTRL_RST;
            ext_irq_enable_reg_r <= EXT_EN_RST;
            wakeup_select_reg_r <= WAKE_SEL_RST;
            irq_mask_r <= IRQ_MASK_RST;
        end else if (wr_low) begin
            if (wr_addr == PIN_CTRL_OFS) begin
                pin_interrupt_control_reg_r <= wr_data[REG_W-1:0];
            end
            if (wr_addr == EXT_EN_OFS) begin
                ext_irq_enable_reg_r <= wr_data[REG_W-1:0];
            end
            if (wr_addr == WAKE_SEL_OFS) begin
                wakeup_select_reg_r <= wr_data[REG_W-1:0];
            end
            if (wr_addr == IRQ_MASK_OFS) begin
                irq_mask_r <= wr_data[EVT_W-1:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // Request detection
    // ------------------------------------------------------------------
    // gated pin path
    // a freshly enabled path can look like an edge
    assign active = pin_interrupt_control_reg_r[PIN_EN_BIT]
        && (pin_interrupt_control_reg_r[POL_BIT] ? i_shared_port_pin : !i_shared_port_pin);
    assign req_set = active && !active_q_r;

    // test-skip valid only with source disabled
    assign skip_clr = i_test_skip_clear_request_op && !ext_irq_enable_reg_r[EXT_EN_BIT];

    // request flag and both enables at a boundary; not while in service
    assign vector_now = external_request_flag_r && ext_irq_enable_reg_r[EXT_EN_BIT]
        && global_irq_enable_flag_r && !in_service_r && i_instr_boundary;

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            active_q_r <= 1'b0;
        end else begin
            active_q_r <= active;
        end
    end

    // A new edge beats a same-cycle clear so no request is lost
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            external_request_flag_r <= 1'b0;
        end else if (req_set) begin
            external_request_flag_r <= 1'b1;
        end else if (skip_clr || vector_now) begin
            external_request_flag_r <= 1'b0;
        end
    end

    // skip reports the flag seen by the test
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_skip_next <= 1'b0;
        end else begin
            o_skip_next <= skip_clr && external_request_flag_r;
        end
    end

    // ------------------------------------------------------------------
    // Acceptance and service tracking
    // ------------------------------------------------------------------
    // acceptance clears the global enable
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            global_irq_enable_flag_r <= 1'b0;
        end else if (vector_now) begin
            global_irq_enable_flag_r <= 1'b0;
        end else if (i_enable_irq_op) begin
            global_irq_enable_flag_r <= 1'b1;
        end else if (i_disable_irq_op) begin
            global_irq_enable_flag_r <= 1'b0;
        end
    end

    // enable during service waits on the return before it can bite
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            in_service_r <= 1'b0;
            o_vector_take <= 1'b0;
        end else begin
            o_vector_take <= vector_now;
            if (vector_now) begin
                in_service_r <= 1'b1;
            end else if (i_return_from_service_op) begin
                in_service_r <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Key-on wakeup
    // ------------------------------------------------------------------
    // a low pin ends back-up at once; does not depend on input enable
    assign wake_cond = i_ram_backup && wakeup_select_reg_r[WAKE_PIN_BIT] && !i_shared_port_pin;

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_wakeup <= 1'b0;
        end else begin
            o_wakeup <= wake_cond;
        end
    end

    // ------------------------------------------------------------------
    // Event status and interrupt line
    // ------------------------------------------------------------------
    always_comb begin
        evt = '0;
        evt[EVT_REQ_BIT] = req_set;
        evt[EVT_VEC_BIT] = vector_now;
        evt[EVT_WAKE_BIT] = wake_cond && !o_wakeup;
    end

    // Set wins over a same-cycle write-one-to-clear
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            irq_sts_r <= '0;
            o_irq <= 1'b0;
        end else begin
            if (wr_low && wr_addr == IRQ_STS_OFS) begin
                irq_sts_r <= (irq_sts_r & ~wr_data[EVT_W-1:0]) | evt;
            end else begin
                irq_sts_r <= irq_sts_r | evt;
            end
            o_irq <= |(irq_sts_r & irq_mask_r);
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);

    sequence enable_then_return;
        i_enable_irq_op ##1 i_return_from_service_op;
    endsequence

    sequence edge_while_gated;
        !pin_interrupt_control_reg_r[PIN_EN_BIT] ##1 !pin_interrupt_control_reg_r[PIN_EN_BIT];
    endsequence

    chk_gated_no_flag: assert property (
        (edge_while_gated and ##1 !$past(external_request_flag_r)) |-> !external_request_flag_r)
        else $error("request flag set while pin input disabled");

    chk_pol_change_flag: assert property (
        ($changed(pin_interrupt_control_reg_r[POL_BIT]) && active && !active_q_r) |=> external_request_flag_r)
        else $error("waveform change with active pin did not set flag");

    chk_enable_change_flag: assert property (
        ($rose(pin_interrupt_control_reg_r[PIN_EN_BIT]) && active) |=> external_request_flag_r)
        else $error("input enable with active pin did not set flag");

    chk_skip_reports_flag: assert property (
        (skip_clr && external_request_flag_r) |=> o_skip_next ##1 (!o_skip_next || $past(skip_clr)))
        else $error("test-skip did not skip on set flag");

    chk_skip_when_enabled: assert property (
        (i_test_skip_clear_request_op && ext_irq_enable_reg_r[EXT_EN_BIT] && external_request_flag_r)
        |=> !o_skip_next && (external_request_flag_r || o_vector_take))
        else $error("test-skip acted while source enabled");

    chk_no_nesting: assert property (
        (in_service_r && !i_return_from_service_op) |=> !o_vector_take)
        else $error("interrupt accepted during service");

    chk_gie_cleared: assert property (
        o_vector_take |-> !global_irq_enable_flag_r && in_service_r)
        else $error("global enable not cleared on acceptance");

    chk_enable_on_return: assert property (
        (in_service_r && !i_disable_irq_op) ##0 enable_then_return
        |=> global_irq_enable_flag_r && !in_service_r)
        else $error("enable then return did not leave interrupts on");

    chk_wake_immediate: assert property (
        (i_ram_backup && wakeup_select_reg_r[WAKE_PIN_BIT] && !i_shared_port_pin) |=> o_wakeup)
        else $error("wakeup not raised for low pin in back-up");

    chk_vector_cause: assert property (
        o_vector_take |-> $past(external_request_flag_r) && $past(ext_irq_enable_reg_r[EXT_EN_BIT])
            && $past(global_irq_enable_flag_r) && $past(i_instr_boundary))
        else $error("vector taken without all enables");

endmodule : ext_pin_irq_ctrl

// *** inc/ext_pin_irq_pkg.sv ***
/*
 * Constants shared by the external pin interrupt block and its register slave:
 * register byte offsets, field positions, reset values and bus response codes.
 * Assumes a 32-bit AXI4-Lite bus with one aligned word per register.
 */
package ext_pin_irq_pkg;

    // ------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] PIN_CTRL_OFS = 8'h00;
    localparam logic [ADDR_W-1:0] EXT_EN_OFS = 8'h04;
    localparam logic [ADDR_W-1:0] WAKE_SEL_OFS = 8'h08;
    localparam logic [ADDR_W-1:0] CORE_STS_OFS = 8'h0C;
    localparam logic [ADDR_W-1:0] IRQ_STS_OFS = 8'h10;
    localparam logic [ADDR_W-1:0] IRQ_MASK_OFS = 8'h14;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int REG_W = 4;
    localparam int PIN_EN_BIT = 3;
    localparam int POL_BIT = 2;
    localparam int EXT_EN_BIT = 0;
    localparam int WAKE_PIN_BIT = 3;
    localparam int STS_FLAG_BIT = 0;
    localparam int STS_GIE_BIT = 1;
    localparam int STS_SERV_BIT = 2;
    localparam int STS_WAKE_BIT = 3;
    localparam int STS_PIN_BIT = 4;
    localparam int EVT_W = 3;
    localparam int EVT_REQ_BIT = 0;
    localparam int EVT_VEC_BIT = 1;
    localparam int EVT_WAKE_BIT = 2;

    // ------------------------------------------------------------------
    // Reset values and responses
    // ------------------------------------------------------------------
    localparam logic [REG_W-1:0] PIN_CTRL_RST = 4'h0;
    localparam logic [REG_W-1:0] EXT_EN_RST = 4'h0;
    localparam logic [REG_W-1:0] WAKE_SEL_RST = 4'h0;
    localparam logic [EVT_W-1:0] IRQ_MASK_RST = 3'h0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : ext_pin_irq_pkg

// *** hdl/axil_reg_slave.sv ***
/*
 * AXI4-Lite slave front end: takes address and data in either order, issues a
 * one-cycle write strobe, and returns read data sampled from the owner's mux.
 * Assumes the owner decodes addresses combinationally and flags unmapped ones.
 */
`timescale 1ns/1ps
module axil_reg_slave
    import ext_pin_irq_pkg::*;
#(
    parameter int AW = ext_pin_irq_pkg::ADDR_W
) (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst,
    // Write channels
    input wire logic [AW-1:0] i_awaddr,
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    input wire logic i_wvalid,
    output logic o_wready,
    output logic [1:0] o_bresp,
    output logic o_bvalid,
    input wire logic i_bready,
    // Read channels
    input wire logic [AW-1:0] i_araddr,
    input wire logic i_arvalid,
    output logic o_arready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    output logic o_rvalid,
    input wire logic i_rready,
    // Register side
    output logic o_wr_en,
    output logic [AW-1:0] o_wr_addr,
    output logic [31:0] o_wr_data,
    output logic [3:0] o_wr_strb,
    input wire logic i_wr_ok,
    output logic [AW-1:0] o_rd_addr,
    input wire logic [31:0] i_rd_data,
    input wire logic i_rd_ok
);

    logic have_aw;
    logic have_w;

    // Both halves held and no response pending
    assign have_aw = !o_awready;
    assign have_w = !o_wready;
    assign o_wr_en = have_aw && have_w && !o_bvalid;

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_awready <= 1'b1;
            o_wr_addr <= '0;
        end else if (i_awvalid && o_awready) begin
            o_awready <= 1'b0;
            o_wr_addr <= i_awaddr;
        end else if (o_wr_en) begin
            o_awready <= 1'b1;
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_wready <= 1'b1;
            o_wr_data <= 32'h0000_0000;
            o_wr_strb <= 4'h0;
        end else if (i_wvalid && o_wready) begin
            o_wready <= 1'b0;
            o_wr_data <= i_wdata;
            o_wr_strb <= i_wstrb;
        end else if (o_wr_en) begin
            o_wready <= 1'b1;
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_bvalid <= 1'b0;
            o_bresp <= RESP_OKAY;
        end else if (o_wr_en) begin
            o_bvalid <= 1'b1;
            o_bresp <= i_wr_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (o_bvalid && i_bready) begin
            o_bvalid <= 1'b0;
        end
    end

    // Read: address taken, data captured one edge later, held until rready
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_arready <= 1'b1;
            o_rd_addr <= '0;
            o_rvalid <= 1'b0;
            o_rdata <= 32'h0000_0000;
            o_rresp <= RESP_OKAY;
        end else if (i_arvalid && o_arready) begin
            o_arready <= 1'b0;
            o_rd_addr <= i_araddr;
        end else if (!o_arready && !o_rvalid) begin
            o_rvalid <= 1'b1;
            o_rdata <= i_rd_data;
            o_rresp <= i_rd_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (o_rvalid && i_rready) begin
            o_rvalid <= 1'b0;
            o_arready <= 1'b1;
        end
    end

endmodule : axil_reg_slave

// *** tb/pin_source_model.sv ***
/*
 * Behavioural source for the shared port pin: drives a level, or releases
 * the pin to its pull-up. Assumes the bench changes its controls on the clock.
 */
`timescale 1ns/1ps
module pin_source_model (
    // Controls from the bench
    input wire logic i_drive_en,
    input wire logic i_level,
    input wire logic i_pull_up,
    // Pin seen by the block
    output logic o_pin
);
    // pull-up with wakeup
    // A released pin without pull-up leaks low, which is what wakes the core
    assign o_pin = i_drive_en ? i_level : i_pull_up;
endmodule : pin_source_model

// *** tb/external_pin_interrupt_control_bench.sv ***
/*
 * Self-checking bench for the external pin interrupt block: AXI4-Lite
 * register tasks, sequencer op strobes and a pin source model.
 * Assumes the design's 20 MHz clock and one-edge answer latencies.
 */
`timescale 1ns/1ps
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin errors++; \
    $display("wrong value at %0t: got %h expected %h", $time, got, exp); end end
module external_pin_interrupt_control_bench;
    import ext_pin_irq_pkg::*;
    logic clk, rst, awvalid, wvalid, bready, arvalid, rready, drv, lvl, pu, backup, bnd;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, d;
    logic [3:0] wstrb, ops;
    logic awready, wready, bvalid, arready, rvalid, vec, skip, wake, irq, pin;
    logic [1:0] bresp, rresp;
    logic [7:0] offs [4] = '{PIN_CTRL_OFS, EXT_EN_OFS, WAKE_SEL_OFS, IRQ_MASK_OFS};
    int errors = 0;
    int compares = 0;
    int vec_cnt = 0;

    pin_source_model src_u (.i_drive_en(drv), .i_level(lvl), .i_pull_up(pu), .o_pin(pin));
    ext_pin_irq_ctrl dut_u (.i_ref_clk(clk), .i_rst(rst), .i_awaddr(awaddr), .i_awvalid(awvalid),
        .o_awready(awready), .i_wdata(wdata), .i_wstrb(wstrb), .i_wvalid(wvalid), .o_wready(wready),
        .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid),
        .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready),
        .i_shared_port_pin(pin), .i_ram_backup(backup), .i_instr_boundary(bnd),
        .i_test_skip_clear_request_op(ops[0]), .i_enable_irq_op(ops[1]), .i_disable_irq_op(ops[2]),
        .i_return_from_service_op(ops[3]), .o_vector_take(vec), .o_skip_next(skip),
        .o_wakeup(wake), .o_irq(irq));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // Counted at the falling edge so the one-cycle pulse is settled
    always @(negedge clk) if (vec === 1'b1) vec_cnt <= vec_cnt + 1;

    task automatic finish_test();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : finish_test

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc

    // ------------------------------------------------------------------
    // Bus and op tasks
    // ------------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
        int n;
        logic ta, tw, tb;
        logic [1:0] r;
        n = 0;
        tb = 1'b0;
        r = 2'bxx;
        @(posedge clk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!tb && n < 50) begin
            @(negedge clk);
            ta = awvalid && awready;
            tw = wvalid && wready;
            tb = bvalid;
            if (bvalid) r = bresp;
            @(posedge clk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            n++;
        end
        bready <= 1'b0;
        `CHK(r, er)
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] v);
        int n;
        logic ta, tr;
        logic [1:0] r;
        n = 0;
        tr = 1'b0;
        r = 2'bxx;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!tr && n < 50) begin
            @(negedge clk);
            ta = arvalid && arready;
            tr = rvalid;
            if (rvalid) begin
                r = rresp;
                v = rdata;
            end
            @(posedge clk);
            if (ta) arvalid <= 1'b0;
            n++;
        end
        rready <= 1'b0;
        `CHK(r, er)
    endtask : rd

    task automatic op(input int i);
        @(posedge clk) ops[i] <= 1'b1;
        @(posedge clk) ops[i] <= 1'b0;
        @(negedge clk);
    endtask : op

    initial begin
        #(4000 * 50);
        errors++;
        finish_test();
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        rst = 1'b1;
        {awvalid, wvalid, bready, arvalid, rready, backup, pu} = '0;
        {awaddr, araddr, wdata, ops} = '0;
        wstrb = 4'hf;
        {drv, lvl, bnd} = 3'b111;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        foreach (offs[i]) begin
            rd(offs[i], RESP_OKAY, d);
            `CHK(d, 32'h0000_0000)
        end
        rd(8'h40, RESP_SLVERR, d);
        `CHK(d, 32'h0000_0000)
        wr(8'h40, 32'h0000_000f, RESP_SLVERR);
        // Input disabled: pin edges leave the flag clear
        @(posedge clk) lvl <= 1'b0;
        cyc(2);
        @(posedge clk) lvl <= 1'b1;
        cyc(2);
        rd(CORE_STS_OFS, RESP_OKAY, d);
        `CHK(d[STS_FLAG_BIT], 1'b0)
        @(posedge clk) lvl <= 1'b0;
        wr(PIN_CTRL_OFS, 32'h0000_0008, RESP_OKAY);
        rd(CORE_STS_OFS, RESP_OKAY, d);
        `CHK(d[STS_FLAG_BIT], 1'b1)
        cyc(1);
        op(0);
        `CHK(skip, 1'b1)
        rd(CORE_STS_OFS, RESP_OKAY, d);
        `CHK(d[STS_FLAG_BIT], 1'b0)
        rd(IRQ_STS_OFS, RESP_OKAY, d);
        `CHK(d[EVT_REQ_BIT], 1'b1)
        wr(IRQ_MASK_OFS, 32'h0000_0001, RESP_OKAY);
        cyc(2);
        `CHK(irq, 1'b1)
        wr(IRQ_STS_OFS, 32'h0000_0001, RESP_OKAY);
        cyc(2);
        `CHK(irq, 1'b0)
        wr(IRQ_MASK_OFS, 32'h0000_0000, RESP_OKAY);
        @(posedge clk) lvl <= 1'b1;
        cyc(2);
        wr(PIN_CTRL_OFS, 32'h0000_000c, RESP_OKAY);
        rd(CORE_STS_OFS, RESP_OKAY, d);
        `CHK(d[STS_FLAG_BIT], 1'b1)
        wr(EXT_EN_OFS, 32'h0000_0001, RESP_OKAY);
        op(0);
        `CHK(skip, 1'b0)
        rd(CORE_STS_OFS, RESP_OKAY, d);
        `CHK(d[STS_FLAG_BIT], 1'b1)
        `CHK(vec_cnt, 0)
        // No boundary, no accept
        @(posedge clk) bnd <= 1'b0;
        op(1);
        cyc(3);
        `CHK(vec_cnt, 0)
        @(posedge clk) bnd <= 1'b1;
        cyc(3);
        `CHK(vec_cnt, 1)
        rd(CORE_STS_OFS, RESP_OKAY, d);
        `CHK(d[2:0], 3'b100)
        // New request while the first one is still in service
        @(posedge clk) lvl <= 1'b0;
        cyc(2);
        @(posedge clk) lvl <= 1'b1;
        cyc(2);
        op(1);
        cyc(4);
        `CHK(vec_cnt, 1)
        op(2);
        @(posedge clk) ops <= 4'b0010;
        @(posedge clk) ops <= 4'b1000;
        @(posedge clk) ops <= 4'b0000;
        cyc(4);
        `CHK(vec_cnt, 2)
        op(3);
        wr(WAKE_SEL_OFS, 32'h0000_0008, RESP_OKAY);
        @(posedge clk) begin
            drv <= 1'b0;
            pu <= 1'b1;
            backup <= 1'b1;
        end
        cyc(3);
        `CHK(wake, 1'b0)
        @(posedge clk) pu <= 1'b0;
        cyc(3);
        `CHK(wake, 1'b1)
        wr(WAKE_SEL_OFS, 32'h0000_0000, RESP_OKAY);
        cyc(3);
        `CHK(wake, 1'b0)
        wr(EXT_EN_OFS, 32'h0000_0000, RESP_OKAY);
        wr(PIN_CTRL_OFS, 32'h0000_0000, RESP_OKAY);
        rd(CORE_STS_OFS, RESP_OKAY, d);
        `CHK(d[STS_FLAG_BIT], 1'b0)
        rd(IRQ_STS_OFS, RESP_OKAY, d);
        `CHK(d[2:0], 3'b111)
        finish_test();
    end
endmodule : external_pin_interrupt_control_bench
